/* logic/ptg_params.svh */
// Constants for the PWM ADC trigger generator: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the modules.
`ifndef PTG_PARAMS_SVH
`define PTG_PARAMS_SVH

`define PTG_ADDR_W          4
`define PTG_OFF_CONTROL     4'h0
`define PTG_OFF_COMPARE     4'h4
`define PTG_OFF_ENABLE      4'h8
`define PTG_OFF_STATUS      4'hc
`define PTG_DIV_HI          15
`define PTG_DIV_LO          12
`define PTG_DLY_HI          5
`define PTG_DLY_LO          0
`define PTG_CONTROL_MASK    16'hf03f
`define PTG_CONTROL_RESET   16'h0000
`define PTG_COMPARE_RESET   16'h0000
`define PTG_TB_PREV_RESET   16'hffff
`define PTG_ENABLE_BIT      0
`define PTG_DIV_W           4
`define PTG_DLY_W           6

`endif

/* logic/ptg_pkg.sv */
// Types shared by the PWM ADC trigger generator files.
// Assumes ptg_params.svh on the include path.
`include "ptg_params.svh"

package ptg_pkg;

	// Trigger control register layout
	typedef struct packed {
		logic [`PTG_DIV_W-1:0] trigger_divider;
		logic [5:0]            unused;
		logic [`PTG_DLY_W-1:0] first_trigger_delay;
	} ptg_control_type;

	// Register bus request
	typedef struct packed {
		logic                   wr;
		logic                   rd;
		logic [`PTG_ADDR_W-1:0] addr;
		logic [15:0]            wdata;
	} ptg_bus_req_type;

	typedef enum logic [1:0] {
		PTG_IDLE  = 2'b00,
		PTG_DELAY = 2'b01,
		PTG_RUN   = 2'b10
	} ptg_state_type;

endpackage

/* logic/ptg_delay.sv */
// Start delay: counts PWM cycles after enable before events may pass.
// Assumes i_period_end pulses once per PWM cycle on the same clock.
`timescale 1ns/100ps
`include "ptg_params.svh"

module ptg_delay
	import ptg_pkg::*;
#(
	parameter int DLY_W = `PTG_DLY_W
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_enable,
	input  wire logic             i_period_end,
	input  wire logic [DLY_W-1:0] i_delay,
	output logic                  o_armed
);

	ptg_state_type    state_q, state_d;
	logic [DLY_W-1:0] cnt_q, cnt_d;

	// Next state; a zero delay arms at once
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			PTG_IDLE: begin
				cnt_d = '0;
				if (i_enable) begin
					state_d = (i_delay == '0) ? PTG_RUN : PTG_DELAY;
				end
			end
			PTG_DELAY: begin
				if (!i_enable) begin
					state_d = PTG_IDLE;
				end else if (i_period_end) begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_d >= i_delay) begin
						state_d = PTG_RUN;
					end
				end
			end
			PTG_RUN: begin
				if (!i_enable) begin
					state_d = PTG_IDLE;
				end
			end
			default: state_d = PTG_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_q <= PTG_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	assign o_armed = (state_q == PTG_RUN);

endmodule // ptg_delay

/* logic/ptg_postscale.sv */
// Postscaler: passes one event out of every divider+1 events.
// Assumes one-cycle event pulses on the same clock.
`timescale 1ns/100ps
`include "ptg_params.svh"

module ptg_postscale
	import ptg_pkg::*;
#(
	parameter int DIV_W = `PTG_DIV_W
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_clear,
	input  wire logic             i_event,
	input  wire logic [DIV_W-1:0] i_divider,
	output logic                  o_pass
);

	logic [DIV_W-1:0] cnt_q, cnt_d;

	// First event after clear passes, then every Nth
	always_comb begin
		cnt_d  = cnt_q;
		o_pass = 1'b0;
		if (i_clear) begin
			cnt_d = '0;
		end else if (i_event) begin
			if (cnt_q == '0) begin
				o_pass = 1'b1;
			end
			cnt_d = (cnt_q >= i_divider) ? '0 : cnt_q + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule // ptg_postscale

/* logic/ptg_trigger.sv */
// PWM ADC trigger generator top: registers, compare, delay, postscale.
// Assumes the time base is on i_ref_clk and sits in local time base mode.
//
// What this block does
// - Postscaler passes one trigger event in every divider-plus-one.
// - After enable, wait start-delay PWM cycles before the first event.
// - Compare value is 16-bit read/write, reset zero.
// - Raise a trigger event when the local time base equals compare.
`timescale 1ns/100ps
`include "ptg_params.svh"

module ptg_trigger
	import ptg_pkg::*;
(
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst_n,
	input  wire logic [`PTG_ADDR_W-1:0] i_addr,
	input  wire logic [15:0]            i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [15:0]            o_rdata,
	input  wire logic [15:0]            i_time_base,
	input  wire logic                   i_period_end,
	input  wire logic                   i_local_time_base,
	output logic                        o_adc_trigger
);

	ptg_bus_req_type req;
	ptg_control_type ctrl_q, ctrl_d;
	logic [15:0]     cmp_q, cmp_d;
	logic            en_q, en_d;
	logic [15:0]     rdata_q, rdata_d;
	logic            trig_q, trig_d;
	logic [15:0]     tb_prev_q;
	logic            cmp_hit;
	logic            armed;
	logic            pass;

	assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

	// Register writes; unused control bits are masked off
	always_comb begin
		ctrl_d = ctrl_q;
		cmp_d  = cmp_q;
		en_d   = en_q;
		if (req.wr) begin
			case (req.addr)
				`PTG_OFF_CONTROL: ctrl_d = req.wdata & `PTG_CONTROL_MASK;
				`PTG_OFF_COMPARE: cmp_d = req.wdata;
				`PTG_OFF_ENABLE:  en_d = req.wdata[`PTG_ENABLE_BIT];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = 16'h0000;
		if (req.rd) begin
			case (req.addr)
				`PTG_OFF_CONTROL: rdata_d = ctrl_q & `PTG_CONTROL_MASK;
				`PTG_OFF_COMPARE: rdata_d = cmp_q;
				`PTG_OFF_ENABLE:  rdata_d = {15'h0000, en_q};
				`PTG_OFF_STATUS:  rdata_d = {15'h0000, armed};
				default:          rdata_d = 16'h0000;
			endcase
		end
	end

	// Match only on arrival at the compare value, so a stalled
	// time base does not fire every clock
	assign cmp_hit = i_local_time_base && (i_time_base == cmp_q)
		&& (tb_prev_q != i_time_base);

	ptg_delay #(
		.DLY_W(`PTG_DLY_W)
	) u_delay (
		.i_ref_clk   (i_ref_clk),
		.i_rst_n     (i_rst_n),
		.i_enable    (en_q),
		.i_period_end(i_period_end),
		.i_delay     (ctrl_q.first_trigger_delay),
		.o_armed     (armed)
	);

	ptg_postscale #(
		.DIV_W(`PTG_DIV_W)
	) u_post (
		.i_ref_clk(i_ref_clk),
		.i_rst_n  (i_rst_n),
		.i_clear  (!armed),
		.i_event  (cmp_hit && armed),
		.i_divider(ctrl_q.trigger_divider),
		.o_pass   (pass)
	);

	assign trig_d = pass;

	// All state registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ctrl_q    <= `PTG_CONTROL_RESET;
			cmp_q     <= `PTG_COMPARE_RESET;
			en_q      <= 1'b0;
			rdata_q   <= 16'h0000;
			trig_q    <= 1'b0;
			tb_prev_q <= `PTG_TB_PREV_RESET;
		end else begin
			ctrl_q    <= ctrl_d;
			cmp_q     <= cmp_d;
			en_q      <= en_d;
			rdata_q   <= rdata_d;
			trig_q    <= trig_d;
			tb_prev_q <= i_time_base;
		end
	end

	assign o_rdata       = rdata_q;
	assign o_adc_trigger = trig_q;

endmodule // ptg_trigger

/* bench/ptg_trigger_asserts.sv */
// Port checker for ptg_trigger: reads and trigger causes.
// Assumes the offsets of ptg_params.svh.
`timescale 1ns/100ps
`include "ptg_params.svh"
module ptg_trigger_asserts (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic [3:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic [15:0] i_time_base,
	input wire logic        i_local_time_base,
	input wire logic        o_adc_trigger
);
	logic [15:0] cmp_q;
	logic        en_q;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// Shadow of compare and enable writes
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cmp_q <= 16'h0000;
			en_q  <= 1'b0;
		end else if (i_wr && i_addr == `PTG_OFF_COMPARE) begin
			cmp_q <= i_wdata;
		end else if (i_wr && i_addr == `PTG_OFF_ENABLE) begin
			en_q <= i_wdata[0];
		end
	end
	a_pulse_one: assert property (o_adc_trigger |=> !o_adc_trigger)
		else $error("long trigger");
	a_hit_cause: assert property (o_adc_trigger |->
		$past(i_time_base) == $past(cmp_q)) else $error("no hit");
	a_local_gate: assert property (!i_local_time_base |=> !o_adc_trigger)
		else $error("not local");
	a_off_quiet: assert property (!en_q [*3] |-> !o_adc_trigger)
		else $error("trigger while off");
	a_cmp_read: assert property (i_rd && i_addr == `PTG_OFF_COMPARE
		|=> o_rdata == cmp_q) else $error("bad compare read");
	a_ctl_unused: assert property (i_rd && i_addr == `PTG_OFF_CONTROL
		|=> o_rdata[11:6] == 6'h00) else $error("unused bits set");
	c_trig: cover property (o_adc_trigger);
	c_ctl: cover property (i_rd && i_addr == `PTG_OFF_CONTROL);
	c_off: cover property (en_q ##1 !en_q);
endmodule // ptg_trigger_asserts
bind ptg_trigger ptg_trigger_asserts u_chk (.i_ref_clk, .i_rst_n, .i_addr,
	.i_wdata, .i_wr, .i_rd, .o_rdata, .i_time_base, .i_local_time_base,
	.o_adc_trigger);

/* bench/ptg_adc_model.sv */
// ADC trigger input: counts conversion starts.
// Assumes one-cycle trigger pulses on i_ref_clk.
`timescale 1ns/100ps
module ptg_adc_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_trigger,
	output logic      [15:0] o_count
);
	// Each sampled pulse starts one conversion
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_count <= 16'h0000;
		end else if (i_trigger) begin
			o_count <= o_count + 16'h0001;
		end
	end
endmodule // ptg_adc_model

/* bench/tb.sv */
// Random bench for ptg_trigger with an ADC counter model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/100ps
`include "ptg_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value %0t %h %h", $time, a, b); end end
module tb;
	logic        i_ref_clk, i_rst_n, i_wr, i_rd, i_period_end, run, lm;
	logic [3:0]  i_addr, d;
	logic [15:0] i_wdata, i_time_base, o_rdata, cnt, c0, v, cm;
	logic        o_adc_trigger;
	int          error_cnt, num_checks, s;
	ptg_trigger DUT (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_time_base, .i_period_end, .i_local_time_base(lm),
		.o_adc_trigger);
	ptg_adc_model u_adc (.i_ref_clk, .i_rst_n, .i_trigger(o_adc_trigger),
		.o_count(cnt));
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	// Time base of 16 counts; held at 15 so a stop makes no hit
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			i_time_base <= 16'h000f;
		end else if (run) begin
			i_time_base <= {12'h000, i_time_base[3:0] + 4'h1};
		end
		i_period_end <= run && i_time_base[3:0] == 4'he;
	end
	task automatic wr(input logic [3:0] a, input logic [15:0] x);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= x;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	// Enable, run np PWM cycles, disable; unused bits get noise
	task automatic trial(input int np, input logic on);
		cm = 16'($urandom % 15);
		wr(`PTG_OFF_COMPARE, cm);
		lm <= on;
		wr(`PTG_OFF_CONTROL, {d, 6'($urandom), 6'(s)});
		wr(`PTG_OFF_ENABLE, 16'h0001);
		c0 = cnt;
		@(posedge i_ref_clk);
		run <= 1'b1;
		repeat (np * 16) @(posedge i_ref_clk);
		run <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		rd(`PTG_OFF_STATUS);
		`CHK(v, 16'h0001)
		wr(`PTG_OFF_ENABLE, 16'h0000);
		rd(`PTG_OFF_STATUS);
		`CHK(v, 16'h0000)
	endtask
	// One hit per PWM cycle once armed; first passes, then every dv+1
	function automatic logic [15:0] exp_trig(input int np, ds, dv, logic on);
		return on ? 16'((np - ds + dv) / (dv + 1)) : 16'h0000;
	endfunction
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge i_ref_clk);
		error_cnt++;
		report_and_stop;
	end
	initial begin
		error_cnt = 0;
		num_checks = 0;
		{i_rst_n, i_wr, i_rd, run, lm} = 5'h01;
		{i_addr, i_wdata} = {4'h0, 16'h0000};
		void'($urandom(32'hc3b8c99b));
		repeat (20) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rd(`PTG_OFF_COMPARE);
		`CHK(v, `PTG_COMPARE_RESET)
		wr(`PTG_OFF_CONTROL, 16'hffff);
		rd(`PTG_OFF_CONTROL);
		`CHK(v, `PTG_CONTROL_MASK)
		// Every divider code, then longest delay, then local mode off
		for (int i = 0; i < 18; i++) begin
			d = (i < 16) ? i[3:0] : 4'($urandom);
			s = (i == 16) ? 63 : (i == 17) ? 0 : int'($urandom % 16);
			trial(s + 20, i != 17);
			`CHK(cnt - c0, exp_trig(s + 20, s, d, lm))
			rd(`PTG_OFF_CONTROL);
			`CHK(v, {d, 6'h00, 6'(s)})
			rd(`PTG_OFF_COMPARE);
			`CHK(v, cm)
		end
		report_and_stop;
	end
endmodule // tb
